// ---- core/adc_host_port.sv ----
/*
 Parallel host port of a 13-bit sampling converter: configuration
 writes, read-back of results, sync pin and ready output.
 Assumes host pins synchronous to i_clock; the analog core is
 modelled by its conversion timing and an external result input.
*/
// Summary of operation
// R01: Write edge strap caught at power up chooses latching strobe edge.
// R02: Host keeps the strap steady after power up.
// R03: Configuration bit 4 makes sync pin input (1) or output (0).
// R04: Input mode: sync rising edge holds sample and starts conversion.
// R05: Output mode: sync high during conversion, low when done.
// R06: Bit 3 clear drives only lines 7..0; set drives all thirteen.
// R07: Data bus is thirteen lines, line 12 most significant.
// R08: Input buffers enabled only with write strobe and select low.
// R09: Bus driven only while read strobe and select low; the enable here follows them one clock late.
// R10: Host clock stays within 0.05 to 12 MHz; the timing here assumes a 5 ns i_clock (200 MHz).
// R11: Active low ready flags start and end of requested functions.
// R12: Full conversion completes within 3.6 microseconds.
// R13: Host request runs self calibration before conversions resume.
// R14: Configuration written through the ordinary select and write cycle.
`timescale 1ns/1ps
`include "adc_host_cfg.svh"
module adc_host_port (
	// Clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	// Host strobes and strap
	input  wire logic               i_chip_select_n,
	input  wire logic               i_write_n,
	input  wire logic               i_read_n,
	input  wire logic               i_write_edge_select,
	// Host data lines, split three ways
	input  wire logic [`DATA_W-1:0] i_host_data_lines,
	output logic      [`DATA_W-1:0] o_host_data_lines,
	output logic      [`DATA_W-1:0] o_host_data_lines_oe,
	// Sync pin, split three ways
	input  wire logic               i_sync,
	output logic                    o_sync,
	output logic                    o_sync_oe,
	// Converter result and ready
	input  wire logic [`DATA_W-1:0] i_conv_result,
	output logic                    o_ready_n
);
	typedef struct packed {
		logic [`DATA_W-1:0]         cfg;
		logic [`DATA_W-1:0]         result;
		adc_host_pkg::conv_state_e  st;
		logic [`CNT_W-1:0]          cnt;
		logic                       sync_prev;
		logic                       sync_out;
		logic                       sync_oe;
		logic                       ready_n;
		logic [`DATA_W-1:0]         dout;
		logic [`DATA_W-1:0]         doe;
	} port_s;

	localparam logic [`CNT_W-1:0] CONV_LAST = `CNT_W'(`CONV_CYCLES - 1);
	localparam logic [`CNT_W-1:0] CAL_LAST  = `CAL_CYCLES - `CNT_W'(1);

	host_strobe_if bus ();

	port_s state_reg;
	port_s state_next;

	host_strobe_decode u_decode (
		.i_clock             (i_clock),
		.i_reset_n           (i_reset_n),
		.i_chip_select_n     (i_chip_select_n),
		.i_write_n           (i_write_n),
		.i_read_n            (i_read_n),
		.i_write_edge_select (i_write_edge_select),
		.i_host_data_lines   (i_host_data_lines),
		.bus                 (bus.decoder)
	);

	// Lane enable mask for the chosen bus width
	function automatic logic [`DATA_W-1:0] lane_mask(input logic wide);
		// R06: narrow bus keeps upper lanes off
		lane_mask = wide ? {`DATA_W{1'b1}}
			: {{(`DATA_W-`NARROW_W){1'b0}}, {`NARROW_W{1'b1}}};
	endfunction

	// Next state of the whole port
	always_comb begin
		logic start;
		start = 1'b0;
		state_next = state_reg;
		state_next.sync_prev = i_sync;
		// R14: config via write cycle
		if (bus.wr_take) begin
			state_next.cfg = bus.wr_data;
		end
		// R04: sync edge starts conversion
		if (state_reg.cfg[`CFG_SYNC_IN_BIT]) begin
			start = i_sync & ~state_reg.sync_prev;
		end else begin
			start = bus.wr_take & bus.wr_data[`CFG_START_BIT];
		end
		unique case (state_reg.st)
			adc_host_pkg::ST_IDLE: begin
				// R13: calibration on request
				if (bus.wr_take && bus.wr_data[`CFG_CAL_BIT]) begin
					state_next.st = adc_host_pkg::ST_CAL;
					state_next.cnt = '0;
				end else if (start) begin
					state_next.st = adc_host_pkg::ST_CONV;
					state_next.cnt = '0;
				end
			end
			adc_host_pkg::ST_CONV: begin
				state_next.cnt = state_reg.cnt + `CNT_W'(1);
				// R12: bounded conversion time
				if (state_reg.cnt == CONV_LAST) begin
					state_next.st = adc_host_pkg::ST_IDLE;
					state_next.result = i_conv_result;
				end
			end
			adc_host_pkg::ST_CAL: begin
				state_next.cnt = state_reg.cnt + `CNT_W'(1);
				// R13: conversions wait for cal
				if (state_reg.cnt == CAL_LAST) begin
					state_next.st = adc_host_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next.st = adc_host_pkg::ST_IDLE;
			end
		endcase
		// R03: sync direction from bit 4
		state_next.sync_oe = ~state_next.cfg[`CFG_SYNC_IN_BIT];
		// R05: sync marks conversion
		state_next.sync_out = state_next.sync_oe
			& (state_next.st == adc_host_pkg::ST_CONV);
		// R11: ready_n high while busy
		state_next.ready_n = (state_next.st != adc_host_pkg::ST_IDLE);
		// R09: drive one clock after a selected read
		// R07: line 12 carries the msb
		state_next.dout = state_next.result;
		state_next.doe = bus.rd_active
			? lane_mask(state_next.cfg[`CFG_BW_BIT]) : '0;
	end

	// Single state register; reset gives input-only, idle, not ready
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= '{cfg: `CFG_RESET, st: adc_host_pkg::ST_IDLE,
				ready_n: 1'b1, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	assign o_host_data_lines    = state_reg.dout;
	assign o_host_data_lines_oe = state_reg.doe;
	assign o_sync               = state_reg.sync_out;
	assign o_sync_oe            = state_reg.sync_oe;
	assign o_ready_n            = state_reg.ready_n;
endmodule

// ---- core/adc_host_cfg.svh ----
/*
 Constants for the parallel host port of the sampling converter.
 Assumes inclusion by bare name from the core files.
*/
`ifndef ADC_HOST_CFG_SVH
`define ADC_HOST_CFG_SVH

`define DATA_W          13
`define NARROW_W        8
`define CFG_BW_BIT      3
`define CFG_SYNC_IN_BIT 4
`define CFG_CAL_BIT     5
`define CFG_START_BIT   6
`define CFG_RESET       13'h0000
`define CONV_TIME_NS    3600
`define CLK_PERIOD_NS   5
`define CAL_CYCLES      12'h400
`define CNT_W           12
`define CONV_CYCLES     (`CONV_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- core/adc_host_pkg.sv ----
/*
 Types shared by the host port modules.
 Assumes adc_host_cfg.svh is on the include path.
*/
`include "adc_host_cfg.svh"
package adc_host_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_CAL  = 2'b11
	} conv_state_e;
endpackage

// ---- core/host_strobe_if.sv ----
/*
 Carrier between the strobe decoder and the port core.
 Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`include "adc_host_cfg.svh"
interface host_strobe_if;
	logic                  wr_take;
	logic [`DATA_W-1:0]    wr_data;
	logic                  rd_active;
	logic                  wr_active;
	modport decoder (output wr_take, output wr_data,
		output rd_active, output wr_active);
	modport core (input wr_take, input wr_data,
		input rd_active, input wr_active);
endinterface

// ---- core/host_strobe_decode.sv ----
/*
 Decodes chip select and strobes, catches the write edge strap.
 Assumes strobes already synchronous to i_clock.
*/
`timescale 1ns/1ps
`include "adc_host_cfg.svh"
module host_strobe_decode (
	// Clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	// Host pins
	input  wire logic               i_chip_select_n,
	input  wire logic               i_write_n,
	input  wire logic               i_read_n,
	input  wire logic               i_write_edge_select,
	input  wire logic [`DATA_W-1:0] i_host_data_lines,
	// To the core
	host_strobe_if.decoder          bus
);
	typedef struct packed {
		logic               strap_taken;
		logic               edge_fall;
		logic               wr_prev;
		logic               take;
		logic [`DATA_W-1:0] data;
	} dec_s;

	dec_s state_reg;
	dec_s state_next;
	logic wr_on;

	// R08: input buffers gated
	assign wr_on = ~i_write_n & ~i_chip_select_n;

	// Strap sampled once after reset release, then edge tracking
	always_comb begin
		state_next = state_reg;
		state_next.take = 1'b0;
		state_next.wr_prev = wr_on;
		// R01: strap caught once
		if (!state_reg.strap_taken) begin
			state_next.strap_taken = 1'b1;
			state_next.edge_fall = i_write_edge_select;
		end
		// R01: latch on chosen edge
		if (state_reg.edge_fall ? (wr_on && !state_reg.wr_prev)
				: (!wr_on && state_reg.wr_prev)) begin
			state_next.take = state_reg.strap_taken;
		end
		// Data held while the strobe is active, so a rising edge sees it
		if (wr_on) begin
			state_next.data = i_host_data_lines;
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Both edge modes use the word latched under the strobe, so the
	// live lines are never read once the input buffers are off
	assign bus.wr_take   = state_reg.take;
	assign bus.wr_data   = state_reg.data;
	assign bus.wr_active = wr_on;
	// R09: output buffers gated
	assign bus.rd_active = ~i_read_n & ~i_chip_select_n;
endmodule

// ---- sim/adc_host_port_asserts.sv ----
/*
 Port checker for the converter host port.
 Assumes binding to adc_host_port; one clock domain.
*/
`timescale 1ns/1ps
`include "adc_host_cfg.svh"
module adc_host_port_asserts (
	// Clock, reset, host inputs
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	input  wire logic               i_chip_select_n,
	input  wire logic               i_read_n,
	input  wire logic               i_sync,
	// Outputs watched
	input  wire logic [`DATA_W-1:0] o_host_data_lines_oe,
	input  wire logic               o_sync,
	input  wire logic               o_sync_oe,
	input  wire logic               o_ready_n
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// Bus drive only follows a selected read
	property p_oe_cause;
		o_host_data_lines_oe != 13'h0
			|-> $past(!i_read_n && !i_chip_select_n);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("drive without read");
	property p_oe_follow;
		!i_read_n && !i_chip_select_n
			|=> o_host_data_lines_oe[7:0] == 8'hff;
	endproperty
	a_oe_follow: assert property (p_oe_follow)
		else $error("read not driven");
	// Upper lines move as one group, never alone
	property p_upper_group;
		o_host_data_lines_oe[12:8] == 5'h0
			|| o_host_data_lines_oe[12:8] == 5'h1f;
	endproperty
	a_upper_group: assert property (p_upper_group)
		else $error("split upper");
	property p_wide_whole;
		o_host_data_lines_oe[12:8] != 5'h0
			|-> o_host_data_lines_oe[7:0] == 8'hff;
	endproperty
	a_wide_whole: assert property (p_wide_whole)
		else $error("partial wide");
	// Sync high only while busy
	property p_sync_busy;
		o_sync_oe && o_sync |-> o_ready_n;
	endproperty
	a_sync_busy: assert property (p_sync_busy)
		else $error("sync when idle");
	property p_conv_len;
		$rose(o_sync) |-> ##[1:721] !o_sync;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion long");
	property p_busy_min;
		$rose(o_ready_n) |-> o_ready_n [*8];
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("busy glitch");
	property p_sync_start;
		!o_sync_oe && $rose(i_sync) && !o_ready_n
			|-> ##[1:6] o_ready_n;
	endproperty
	a_sync_start: assert property (p_sync_start)
		else $error("no sync start");
endmodule
bind adc_host_port adc_host_port_asserts u_chk (.i_clock, .i_reset_n,
	.i_chip_select_n, .i_read_n, .i_sync, .o_host_data_lines_oe,
	.o_sync, .o_sync_oe, .o_ready_n);

// ---- sim/host_bus_model.sv ----
/*
 Host side of the parallel bus: strobes and write data.
 Assumes driving on falling clock edges; wire resolved by the bench.
*/
`timescale 1ns/1ps
`include "adc_host_cfg.svh"
module host_bus_model (
	// Clock and device bus
	input  wire logic               i_clock,
	input  wire logic [`DATA_W-1:0] i_q,
	input  wire logic [`DATA_W-1:0] i_q_oe,
	// Host strobes and data
	output logic                    o_cs_n = 1'b1,
	output logic                    o_wr_n = 1'b1,
	output logic                    o_rd_n = 1'b1,
	output logic [`DATA_W-1:0]      o_dq = 13'h0
);
	// ordinary write cycle; data only under strobe
	task wr(input logic [`DATA_W-1:0] v, input int hold);
		@(negedge i_clock);
		o_cs_n = 1'b0;
		o_wr_n = 1'b0;
		o_dq = v;
		repeat (hold) @(negedge i_clock);
		o_wr_n = 1'b1;
		o_cs_n = 1'b1;
		o_dq = ~v; // Released: stale value would hide faults
		repeat (2) @(negedge i_clock);
	endtask
	task rd(output logic [`DATA_W-1:0] v, output logic [`DATA_W-1:0] oe);
		@(negedge i_clock);
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		repeat (2) @(negedge i_clock);
		v = i_q;
		oe = i_q_oe;
		o_rd_n = 1'b1;
		o_cs_n = 1'b1;
		repeat (2) @(negedge i_clock);
	endtask
endmodule

// ---- sim/adc_parallel_host_interface_test.sv ----
/*
 Self-checking bench for the converter host port.
 Assumes host_bus_model plays the processor; bound checker present.
*/
`timescale 1ns/1ps
`include "adc_host_cfg.svh"
module adc_parallel_host_interface_test;
	logic               i_clock = 1'b0;
	logic               i_reset_n = 1'b0;
	logic               strap = 1'b1;
	logic               sync_in = 1'b0;
	logic [`DATA_W-1:0] result = 13'h1abc;
	logic               cs_n, wr_n, rd_n, sync_o, sync_oe, ready_n;
	logic [`DATA_W-1:0] dq, q, q_oe, v, oe;
	int                 bad_count = 0;
	int                 n_checks = 0;
	always #2.5 i_clock = ~i_clock;
	adc_host_port uut (.i_clock, .i_reset_n, .i_chip_select_n(cs_n),
		.i_write_n(wr_n), .i_read_n(rd_n), .i_write_edge_select(strap),
		.i_host_data_lines((q & q_oe) | (dq & ~q_oe)),
		.o_host_data_lines(q), .o_host_data_lines_oe(q_oe), .i_sync(sync_in),
		.o_sync(sync_o), .o_sync_oe(sync_oe), .i_conv_result(result),
		.o_ready_n(ready_n));
	host_bus_model host (.i_clock, .i_q(q), .i_q_oe(q_oe), .o_cs_n(cs_n),
		.o_wr_n(wr_n), .o_rd_n(rd_n), .o_dq(dq));
	task chk(input string s, input logic [12:0] e, input logic [12:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	// Strap set only under reset, then left alone
	task rst(input logic s);
		@(negedge i_clock);
		i_reset_n = 1'b0;
		strap = s;
		repeat (10) @(negedge i_clock);
		i_reset_n = 1'b1;
		repeat (3) @(negedge i_clock);
	endtask
	task idle(input int n);
		for (int k = 0; k < n && ready_n !== 1'b0; k++) @(negedge i_clock);
		chk("ready_n", 13'h0, 13'(ready_n));
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Narrow read, then a started conversion on the full bus
	task t_conv;
		host.rd(v, oe);
		chk("narrow oe", 13'h00ff, oe);
		host.wr(13'h0048, 40);
		chk("sync", 13'h1, 13'(sync_o));
		// Busy in the next to last of its 720 cycles, then ready
		repeat (678) @(negedge i_clock);
		chk("conv busy", 13'h1, 13'(ready_n));
		idle(3);
		chk("sync end", 13'h0, 13'(sync_o));
		host.rd(v, oe);
		chk("wide oe", 13'h1fff, oe);
		chk("wide data", 13'h1abc, v & oe);
	endtask
	// Sync pin as input starts conversions
	task t_sync;
		host.wr(13'h0018, 2);
		repeat (4) @(negedge i_clock);
		chk("sync_oe", 13'h0, 13'(sync_oe));
		result = 13'h0a55;
		sync_in = 1'b1;
		repeat (6) @(negedge i_clock);
		chk("busy", 13'h1, 13'(ready_n));
		sync_in = 1'b0;
		idle(725);
		host.rd(v, oe);
		chk("sync data", 13'h0a55, v & oe);
	endtask
	// Calibration keeps the port busy
	task t_cal;
		host.wr(13'h0038, 2);
		repeat (900) @(negedge i_clock);
		chk("cal busy", 13'h1, 13'(ready_n));
		idle(200);
	endtask
	// Strap low latches on strobe release
	task t_edge;
		rst(1'b0);
		host.wr(13'h0048, 40);
		repeat (700) @(negedge i_clock);
		chk("late start", 13'h1, 13'(ready_n));
		idle(40);
	endtask
	initial begin
		rst(1'b1);
		chk("ready_n", 13'h0, 13'(ready_n));
		chk("sync_oe", 13'h1, 13'(sync_oe));
		t_conv();
		t_sync();
		t_cal();
		t_edge();
		report_and_stop();
	end
	// Watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge i_clock);
		bad_count++;
		report_and_stop();
	end
endmodule
